/* File: ppcr_defs.svh */
// Constants for the port pad configuration register bank
`ifndef PPCR_DEFS_SVH
`define PPCR_DEFS_SVH

// ---------------------------------------------------------------
// Special-function addresses and pages
// ---------------------------------------------------------------
`define PPCR_ADDR_AIO_P1 8'h92
`define PPCR_ADDR_AIO_B 8'h92
`define PPCR_ADDR_AIO_A 8'h94
`define PPCR_ADDR_CFG_B4 8'hb4
`define PPCR_PAGE_PORT1_ANALOG_ONLY 4'h0
`define PPCR_PAGE_AIO_B 4'h1
`define PPCR_PAGE_AIO_A 4'h0
`define PPCR_PAGE_PULLUP 4'h1
`define PPCR_PAGE_DRV_LO 4'h2
`define PPCR_PAGE_DRV_HI 4'h3

// ---------------------------------------------------------------
// Reset values and implemented-bit masks
// ---------------------------------------------------------------
`define PPCR_RESET_VAL 8'h00
`define PPCR_MASK_PULLUP 8'h1f
`define PPCR_MASK_DRV_HI 8'h7f
`define PPCR_MASK_FULL 8'hff

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define PPCR_PU_P7_LO 4
`define PPCR_PU_P6_HI 3
`define PPCR_PU_P6_LO 2
`define PPCR_PU_P5_HI 1
`define PPCR_PU_P5_LO 0
`define PPCR_AIOA_COMP_C 0
`define PPCR_AIOB_P2_PIN0 7
`define PPCR_DRV_P7 6
`define PPCR_DRV_P6_HI 5
`define PPCR_DRV_P6_LO 4

`endif

/* File: ppcr_pkg.sv */
// Types for the port pad configuration register bank
package ppcr_pkg;
   typedef logic [7:0] ppcr_byte_t;
   typedef enum logic [5:0] {
      PPCR_SEL_NONE = 6'b000001,
      PPCR_SEL_PORT1_ANALOG_ONLY = 6'b000010,
      PPCR_SEL_AIOB = 6'b000100,
      PPCR_SEL_AIOA = 6'b001000,
      PPCR_SEL_PU = 6'b010000,
      PPCR_SEL_DRV = 6'b100000
   } ppcr_sel_t;
endpackage

/* File: ppcr_cfg_reg.sv */
// One masked configuration register with reset and write strobe
`timescale 1ns/1ns
`default_nettype none
`include "ppcr_defs.svh"
module ppcr_cfg_reg #(
   parameter logic [7:0] MASK = `PPCR_MASK_FULL
) (
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   input wire logic wr_i,
   input wire logic [7:0] data_i,
   output logic [7:0] value_o
);
   logic [7:0] value_q;
   // Reserved bits are never stored, so they always read as zero
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         value_q <= `PPCR_RESET_VAL;
      end else if (wr_i) begin
         value_q <= data_i & MASK;
      end
   end
   assign value_o = value_q;
endmodule
`default_nettype wire

/* File: ppcr_top.sv */
// Port pad configuration registers: pull-ups, analog-only, drive
// ---------------------------------------------------------------
// Summary of operation
// - Pull-up bit 4 enables port 7 pins 2..0 pull-ups in open-drain.
// - Bits 3 and 2 enable port 6 high and low nibble pull-ups.
// - Bits 1 and 0 enable port 5 high and low nibble pull-ups.
// - Port 1 analog-only bits make matching pins analog converter only.
// - Analog-only pins read zero in the port pin register.
// - Shared register A bits 7,6 make port 0 pins 7,6 analog-only.
// - Shared register A bits 5..1 make port 0 pins 5..1 analog-only.
// - Comparator C bit and negative select pick port 6 pins 3,2 analog.
// - Shared register B bit 7 makes port 2 pin 0 analog-only.
// - Shared register B bits 6..0 make port 5 pins 6..0 analog-only.
// - Low drive register holds one bit per nibble of ports 3..0.
// - Drive bit 0 selects high strength, 1 selects low strength.
// - Port 4 pin 7 and port 6 pins 1,0 have no drive select.
// - High drive register bit 6 port 7, then ports 6, 5, 4 nibbles.
// - Port 6 low bit drives pins 3,2; port 4 high drives pins 6..4.
// - Mode bit 0 is open-drain; pull-ups act only when open-drain.
// ---------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
`include "ppcr_defs.svh"
module ppcr_top (
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   input wire logic [7:0] SFR_ADDR_I,
   input wire logic [3:0] SFR_PAGE_I,
   input wire logic SFR_WR_I,
   input wire logic SFR_RD_I,
   input wire logic [7:0] SFR_WDATA_I,
   output logic [7:0] SFR_RDATA_O,
   output logic SFR_HIT_O,
   input wire logic [7:0] P5_MODE_I,
   input wire logic [7:0] P6_MODE_I,
   input wire logic [2:0] P7_MODE_I,
   input wire logic [7:0] P0_PIN_I,
   input wire logic [7:0] P1_PIN_I,
   input wire logic [7:0] P2_PIN_I,
   input wire logic [7:0] P5_PIN_I,
   input wire logic [7:0] P6_PIN_I,
   input wire logic COMP_C_NEG_SEL_I,
   output logic [7:0] P0_PIN_READ_O,
   output logic [7:0] P1_PIN_READ_O,
   output logic [7:0] P2_PIN_READ_O,
   output logic [7:0] P5_PIN_READ_O,
   output logic [7:0] P6_PIN_READ_O,
   output logic [7:0] P5_PULLUP_O,
   output logic [7:0] P6_PULLUP_O,
   output logic [2:0] P7_PULLUP_O,
   output logic [7:0] P0_ANALOG_ONLY_O,
   output logic [7:0] P1_ANALOG_ONLY_O,
   output logic [7:0] P2_ANALOG_ONLY_O,
   output logic [7:0] P5_ANALOG_ONLY_O,
   output logic [7:0] P6_ANALOG_ONLY_O,
   output logic [7:0] P0_LOW_DRIVE_O,
   output logic [7:0] P1_LOW_DRIVE_O,
   output logic [7:0] P2_LOW_DRIVE_O,
   output logic [7:0] P3_LOW_DRIVE_O,
   output logic [7:0] P4_LOW_DRIVE_O,
   output logic [7:0] P5_LOW_DRIVE_O,
   output logic [7:0] P6_LOW_DRIVE_O,
   output logic [2:0] P7_LOW_DRIVE_O
);

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   // Decode is used by both the write strobes and the read mux
   function automatic ppcr_pkg::ppcr_sel_t decode_sel(
      input logic [7:0] addr,
      input logic [3:0] page
   );
      ppcr_pkg::ppcr_sel_t sel;
      sel = ppcr_pkg::PPCR_SEL_NONE;
      if (addr == `PPCR_ADDR_AIO_P1 && page == `PPCR_PAGE_PORT1_ANALOG_ONLY) begin
         sel = ppcr_pkg::PPCR_SEL_PORT1_ANALOG_ONLY;
      end else if (addr == `PPCR_ADDR_AIO_B && page == `PPCR_PAGE_AIO_B) begin
         sel = ppcr_pkg::PPCR_SEL_AIOB;
      end else if (addr == `PPCR_ADDR_AIO_A && page == `PPCR_PAGE_AIO_A) begin
         sel = ppcr_pkg::PPCR_SEL_AIOA;
      end else if (addr == `PPCR_ADDR_CFG_B4 &&
                   page == `PPCR_PAGE_PULLUP) begin
         sel = ppcr_pkg::PPCR_SEL_PU;
      end else if (addr == `PPCR_ADDR_CFG_B4 &&
                   (page == `PPCR_PAGE_DRV_LO ||
                    page == `PPCR_PAGE_DRV_HI)) begin
         sel = ppcr_pkg::PPCR_SEL_DRV;
      end
      return sel;
   endfunction

   ppcr_pkg::ppcr_sel_t sel;
   logic [5:0] wr_vec;
   logic [7:0] regs [6];
   logic [7:0] pu_v, aio_a_v, aio_b_v, port1_analog_only_v, drv_lo_v, drv_hi_v;

   assign sel = decode_sel(SFR_ADDR_I, SFR_PAGE_I);
   assign SFR_HIT_O = (sel != ppcr_pkg::PPCR_SEL_NONE);

   // One strobe per register; drive pages split the shared case
   always_comb begin
      wr_vec = 6'h00;
      if (SFR_WR_I) begin
         case (sel)
            ppcr_pkg::PPCR_SEL_PORT1_ANALOG_ONLY: wr_vec[0] = 1'b1;
            ppcr_pkg::PPCR_SEL_AIOB: wr_vec[1] = 1'b1;
            ppcr_pkg::PPCR_SEL_AIOA: wr_vec[2] = 1'b1;
            ppcr_pkg::PPCR_SEL_PU: wr_vec[3] = 1'b1;
            ppcr_pkg::PPCR_SEL_DRV: begin
               if (SFR_PAGE_I == `PPCR_PAGE_DRV_LO) begin
                  wr_vec[4] = 1'b1;
               end else begin
                  wr_vec[5] = 1'b1;
               end
            end
            default: wr_vec = 6'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Register storage
   // ------------------------------------------------------------
   // Masks drop reserved bits, so a careless write cannot set them
   localparam logic [7:0] MASKS [6] = '{`PPCR_MASK_FULL,
      `PPCR_MASK_FULL, `PPCR_MASK_FULL, `PPCR_MASK_PULLUP,
      `PPCR_MASK_FULL, `PPCR_MASK_DRV_HI};

   // reset zero, reserved bits not stored
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_reg
         ppcr_cfg_reg #(.MASK(MASKS[gi])) ppcr_cfg_reg_i (
            .REF_CLK_I(REF_CLK_I),
            .RST_I(RST_I),
            .wr_i(wr_vec[gi]),
            .data_i(SFR_WDATA_I),
            .value_o(regs[gi])
         );
      end
   endgenerate

   assign port1_analog_only_v = regs[0];
   assign aio_b_v = regs[1];
   assign aio_a_v = regs[2];
   assign pu_v = regs[3];
   assign drv_lo_v = regs[4];
   assign drv_hi_v = regs[5];

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   // Registered read data; unmapped reads return zero
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         SFR_RDATA_O <= 8'h00;
      end else if (SFR_RD_I) begin
         case (sel)
            ppcr_pkg::PPCR_SEL_PORT1_ANALOG_ONLY: SFR_RDATA_O <= port1_analog_only_v;
            ppcr_pkg::PPCR_SEL_AIOB: SFR_RDATA_O <= aio_b_v;
            ppcr_pkg::PPCR_SEL_AIOA: SFR_RDATA_O <= aio_a_v;
            ppcr_pkg::PPCR_SEL_PU: SFR_RDATA_O <= pu_v;
            ppcr_pkg::PPCR_SEL_DRV: SFR_RDATA_O <=
               (SFR_PAGE_I == `PPCR_PAGE_DRV_LO) ? drv_lo_v : drv_hi_v;
            default: SFR_RDATA_O <= 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Pull-up enables
   // ------------------------------------------------------------
   // pull-ups only while the pin is open-drain (mode bit 0)
   assign P7_PULLUP_O = {3{pu_v[`PPCR_PU_P7_LO]}} & ~P7_MODE_I;
   assign P6_PULLUP_O = {{4{pu_v[`PPCR_PU_P6_HI]}},
      {4{pu_v[`PPCR_PU_P6_LO]}}} & ~P6_MODE_I;
   assign P5_PULLUP_O = {{4{pu_v[`PPCR_PU_P5_HI]}},
      {4{pu_v[`PPCR_PU_P5_LO]}}} & ~P5_MODE_I;

   // ------------------------------------------------------------
   // Analog-only selection
   // ------------------------------------------------------------
   logic comp_c_on;
   assign comp_c_on = aio_a_v[`PPCR_AIOA_COMP_C];
   assign P1_ANALOG_ONLY_O = port1_analog_only_v;
   // port 0 pins 7..1; pin 0 has no analog-only bit
   assign P0_ANALOG_ONLY_O = {aio_a_v[7:1], 1'b0};
   assign P2_ANALOG_ONLY_O = {7'h00, aio_b_v[`PPCR_AIOB_P2_PIN0]};
   assign P5_ANALOG_ONLY_O = {1'b0, aio_b_v[6:0]};
   // comparator C pins; when off the pins follow their mode bits
   assign P6_ANALOG_ONLY_O = {4'h0, comp_c_on,
      comp_c_on & ~COMP_C_NEG_SEL_I, 2'b00};

   // analog-only pins read back as zero
   assign P0_PIN_READ_O = P0_PIN_I & ~P0_ANALOG_ONLY_O;
   assign P1_PIN_READ_O = P1_PIN_I & ~P1_ANALOG_ONLY_O;
   assign P2_PIN_READ_O = P2_PIN_I & ~P2_ANALOG_ONLY_O;
   assign P5_PIN_READ_O = P5_PIN_I & ~P5_ANALOG_ONLY_O;
   assign P6_PIN_READ_O = P6_PIN_I & ~P6_ANALOG_ONLY_O;

   // ------------------------------------------------------------
   // Drive strength (1 = low strength)
   // ------------------------------------------------------------
   // ports 0..3 by nibble
   assign P0_LOW_DRIVE_O = {{4{drv_lo_v[1]}}, {4{drv_lo_v[0]}}};
   assign P1_LOW_DRIVE_O = {{4{drv_lo_v[3]}}, {4{drv_lo_v[2]}}};
   assign P2_LOW_DRIVE_O = {{4{drv_lo_v[5]}}, {4{drv_lo_v[4]}}};
   assign P3_LOW_DRIVE_O = {{4{drv_lo_v[7]}}, {4{drv_lo_v[6]}}};
   // port 4 pin 7 and port 6 pins 1,0 fixed high
   assign P4_LOW_DRIVE_O = {1'b0, {3{drv_hi_v[1]}}, {4{drv_hi_v[0]}}};
   assign P5_LOW_DRIVE_O = {{4{drv_hi_v[3]}}, {4{drv_hi_v[2]}}};
   assign P6_LOW_DRIVE_O = {{4{drv_hi_v[`PPCR_DRV_P6_HI]}},
      {2{drv_hi_v[`PPCR_DRV_P6_LO]}}, 2'b00};
   assign P7_LOW_DRIVE_O = {3{drv_hi_v[`PPCR_DRV_P7]}};

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // pull-up follows a write on the next edge
   pu_write_takes_a: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      (wr_vec[3] && SFR_WDATA_I[4]) |=> pu_v[4])
      else $error("pull-up write not taken");
   pu_pushpull_off_a: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      ((P5_PULLUP_O & P5_MODE_I) | (P6_PULLUP_O & P6_MODE_I)) == 8'h00)
      else $error("pull-up on push-pull pin");
   // port 6 high nibble tracks bit 3
   pu_p6_high_a: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      (pu_v[3] && P6_MODE_I[7:4] == 4'h0) |-> P6_PULLUP_O[7:4] == 4'hf)
      else $error("port 6 high pull-up wrong");
   // port 5 low nibble tracks bit 0
   pu_p5_low_a: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      (!pu_v[0]) |-> P5_PULLUP_O[3:0] == 4'h0)
      else $error("port 5 low pull-up wrong");
   pin_read_zero_a: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      (P1_PIN_READ_O & port1_analog_only_v) == 8'h00)
      else $error("analog pin read not zero");
   // negative select keeps pin 2 digital
   comp_c_select_a: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      (comp_c_on && COMP_C_NEG_SEL_I) |-> P6_ANALOG_ONLY_O[3:2] == 2'b10)
      else $error("comparator pin routing wrong");
   fixed_drive_pins_a: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      !P4_LOW_DRIVE_O[7] && P6_LOW_DRIVE_O[1:0] == 2'b00)
      else $error("fixed drive pin changed");
   // reserved bits read zero after any pull-up or high drive write
   reserved_zero_a: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      (wr_vec[5] || wr_vec[3]) |=> (!drv_hi_v[7] && pu_v[7:5] == 3'h0))
      else $error("reserved bit stored");
   // everything clear one edge after a reset edge
   reset_clear_a: assert property (
      @(posedge REF_CLK_I)
      RST_I |=> (pu_v == 8'h00 && drv_lo_v == 8'h00 && drv_hi_v == 8'h00
         && port1_analog_only_v == 8'h00 && aio_a_v == 8'h00 && aio_b_v == 8'h00
         && SFR_RDATA_O == 8'h00))
      else $error("register not cleared by reset");
   // port 1 analog bits follow the written byte
   p1_analog_write_a: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      wr_vec[0] |=> P1_ANALOG_ONLY_O == $past(SFR_WDATA_I))
      else $error("port 1 analog-only write wrong");
   // port 0 pins 7..1 follow shared register A
   p0_analog_write_a: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      wr_vec[2] |=> P0_ANALOG_ONLY_O == ($past(SFR_WDATA_I) & 8'hfe))
      else $error("port 0 analog-only write wrong");
   // port 2 pin 0 and port 5 pins follow register B
   aio_b_write_a: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      wr_vec[1] |=> {P2_ANALOG_ONLY_O[0], P5_ANALOG_ONLY_O[6:0]} ==
         $past(SFR_WDATA_I))
      else $error("register B analog-only write wrong");
   // one low-drive bit per nibble of ports 3..0
   drive_lo_write_a: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      wr_vec[4] |=> {P3_LOW_DRIVE_O[7], P3_LOW_DRIVE_O[0],
         P2_LOW_DRIVE_O[7], P2_LOW_DRIVE_O[0], P1_LOW_DRIVE_O[7],
         P1_LOW_DRIVE_O[0], P0_LOW_DRIVE_O[7], P0_LOW_DRIVE_O[0]} ==
         $past(SFR_WDATA_I))
      else $error("low ports drive write wrong");
   // port 7, 6, 5 and 4 groups follow the high register
   drive_hi_write_a: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      wr_vec[5] |=> {1'b0, P7_LOW_DRIVE_O[0], P6_LOW_DRIVE_O[7],
         P6_LOW_DRIVE_O[2], P5_LOW_DRIVE_O[7], P5_LOW_DRIVE_O[0],
         P4_LOW_DRIVE_O[6], P4_LOW_DRIVE_O[0]} ==
         ($past(SFR_WDATA_I) & `PPCR_MASK_DRV_HI))
      else $error("high ports drive write wrong");
   // a read of the pull-up address and page returns the pull-up register
   read_back_a: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      (SFR_RD_I && sel == ppcr_pkg::PPCR_SEL_PU) |=>
         SFR_RDATA_O == $past(pu_v))
      else $error("pull-up read back wrong");
endmodule
`default_nettype wire

/* File: ppcr_top_tb_top.sv */
// Self-checking testbench for the port pad configuration register bank
`timescale 1ns/1ns
`default_nettype none
`include "ppcr_defs.svh"
module ppcr_top_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic sel = 1'b0;
   logic [3:0] page = 4'h0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [7:0] m5 = 8'h00, m6 = 8'h00;
   logic [2:0] m7 = 3'h0;
   logic [7:0] p0 = 8'h00, p1 = 8'h00, p2 = 8'h00, p5 = 8'h00, p6 = 8'h00;
   logic [7:0] rdata, r0, r1, r2, r5, r6, u5, u6, a0, a1, a2, a5, a6;
   logic [7:0] d0, d1, d2, d3, d4, d5, d6;
   logic [2:0] u7, d7;
   logic hit;
   int n_errors = 0;
   int samples_checked = 0;

   // ------------------------------------------------------------
   // Clock, device and watchdog
   // ------------------------------------------------------------
   // Clock at 100 MHz
   initial begin
      forever #5 clk = ~clk;
   end

   ppcr_top ppcr_top_i (
      .REF_CLK_I(clk), .RST_I(rst), .SFR_ADDR_I(addr), .SFR_PAGE_I(page),
      .SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_WDATA_I(wdata),
      .SFR_RDATA_O(rdata), .SFR_HIT_O(hit),
      .P5_MODE_I(m5), .P6_MODE_I(m6), .P7_MODE_I(m7),
      .P0_PIN_I(p0), .P1_PIN_I(p1), .P2_PIN_I(p2), .P5_PIN_I(p5),
      .P6_PIN_I(p6), .COMP_C_NEG_SEL_I(sel), .P0_PIN_READ_O(r0),
      .P1_PIN_READ_O(r1), .P2_PIN_READ_O(r2), .P5_PIN_READ_O(r5),
      .P6_PIN_READ_O(r6), .P5_PULLUP_O(u5), .P6_PULLUP_O(u6),
      .P7_PULLUP_O(u7), .P0_ANALOG_ONLY_O(a0), .P1_ANALOG_ONLY_O(a1),
      .P2_ANALOG_ONLY_O(a2), .P5_ANALOG_ONLY_O(a5), .P6_ANALOG_ONLY_O(a6),
      .P0_LOW_DRIVE_O(d0), .P1_LOW_DRIVE_O(d1), .P2_LOW_DRIVE_O(d2),
      .P3_LOW_DRIVE_O(d3), .P4_LOW_DRIVE_O(d4), .P5_LOW_DRIVE_O(d5),
      .P6_LOW_DRIVE_O(d6), .P7_LOW_DRIVE_O(d7)
   );

   // Hang guard: the whole run needs far fewer cycles than this
   initial begin
      repeat (3000) @(posedge clk);
      n_errors++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      conclude();
   end

   // ------------------------------------------------------------
   // Bus and compare tasks
   // ------------------------------------------------------------
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Inputs change on the falling edge, one write per strobed cycle
   task automatic sfr_wr(input logic [7:0] a, input logic [3:0] p,
                         input logic [7:0] d);
      @(negedge clk);
      addr = a;
      page = p;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask

   // Read data is registered, so it is taken one edge later
   task automatic chk_reg(input logic [7:0] a, input logic [3:0] p,
                          input logic [7:0] exp, input string what);
      @(negedge clk);
      addr = a;
      page = p;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      cmp8(rdata, exp, what);
   endtask

   task automatic conclude;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Every register, the pull-up and analog outputs and the port 0, 3, 4, 6 drive outputs start cleared
   task automatic test_reset;
      chk_reg(`PPCR_ADDR_AIO_P1, `PPCR_PAGE_PORT1_ANALOG_ONLY, 8'h00, "p1 aio rst");
      chk_reg(`PPCR_ADDR_AIO_B, `PPCR_PAGE_AIO_B, 8'h00, "aio b rst");
      chk_reg(`PPCR_ADDR_AIO_A, `PPCR_PAGE_AIO_A, 8'h00, "aio a rst");
      chk_reg(`PPCR_ADDR_CFG_B4, `PPCR_PAGE_PULLUP, 8'h00, "pu rst");
      chk_reg(`PPCR_ADDR_CFG_B4, `PPCR_PAGE_DRV_LO, 8'h00, "dlo rst");
      chk_reg(`PPCR_ADDR_CFG_B4, `PPCR_PAGE_DRV_HI, 8'h00, "dhi rst");
      cmp8(u6 | u5 | {5'h00, u7}, 8'h00, "pullups rst");
      cmp8(a0 | a1 | a2 | a5 | a6, 8'h00, "analog rst");
      cmp8(d0 | d3 | d4 | d6, 8'h00, "drive rst");
   endtask

   // Pull-ups follow the enables only while pins are open-drain
   task automatic test_pullup;
      sfr_wr(`PPCR_ADDR_CFG_B4, `PPCR_PAGE_PULLUP, 8'h1f);
      chk_reg(`PPCR_ADDR_CFG_B4, `PPCR_PAGE_PULLUP, 8'h1f, "pu read");
      cmp8(u5, 8'hff, "p5 pullup");
      cmp8(u6, 8'hff, "p6 pullup");
      cmp8({5'h00, u7}, 8'h07, "p7 pullup");
      sfr_wr(`PPCR_ADDR_CFG_B4, `PPCR_PAGE_PULLUP, 8'h15);
      cmp8(u5, 8'h0f, "p5 low only");
      cmp8(u6, 8'h0f, "p6 low only");
      m5 = 8'h03;
      m7 = 3'h5;
      #1;
      cmp8(u5, 8'h0c, "p5 push-pull");
      cmp8({5'h00, u7}, 8'h02, "p7 push-pull");
   endtask

   // Analog-only bits mask the pin reads of the same pins
   task automatic test_analog;
      @(negedge clk);
      {p0, p1, p2, p5, p6} = {5{8'hff}};
      sfr_wr(`PPCR_ADDR_AIO_P1, `PPCR_PAGE_PORT1_ANALOG_ONLY, 8'ha5);
      cmp8(a1, 8'ha5, "p1 analog");
      cmp8(r1, 8'h5a, "p1 pin read");
      sfr_wr(`PPCR_ADDR_AIO_B, `PPCR_PAGE_AIO_B, 8'h81);
      cmp8(a2, 8'h01, "p2 analog");
      cmp8(a5, 8'h01, "p5 analog");
      cmp8(r2 & r5, 8'hfe, "p2 p5 read");
      chk_reg(`PPCR_ADDR_AIO_P1, `PPCR_PAGE_PORT1_ANALOG_ONLY, 8'ha5, "page split");
      sfr_wr(`PPCR_ADDR_AIO_A, `PPCR_PAGE_AIO_A, 8'hfe);
      cmp8(a0, 8'hfe, "p0 analog");
      cmp8(r0 | a6, 8'h01, "p0 read");
      sfr_wr(`PPCR_ADDR_AIO_A, `PPCR_PAGE_AIO_A, 8'h01);
      cmp8(a6, 8'h0c, "comp c both");
      cmp8(r6, 8'hf3, "p6 read");
      sel = 1'b1;
      #1;
      cmp8(a6, 8'h08, "comp c pos");
   endtask

   // Drive strength bits expand over their nibbles; 1 means weak
   task automatic test_drive;
      sfr_wr(`PPCR_ADDR_CFG_B4, `PPCR_PAGE_DRV_LO, 8'h5a);
      cmp8(d3 & d2, 8'h0f, "p3 p2 drive");
      cmp8(d1 & d0, 8'hf0, "p1 p0 drive");
      sfr_wr(`PPCR_ADDR_CFG_B4, `PPCR_PAGE_DRV_HI, 8'h7f);
      chk_reg(`PPCR_ADDR_CFG_B4, `PPCR_PAGE_DRV_HI, 8'h7f, "dhi read");
      cmp8(d4, 8'h7f, "p4 drive");
      cmp8(d6, 8'hfc, "p6 drive");
      cmp8({5'h00, d7} | {d5 ^ 8'hff}, 8'h07, "p5 p7 drive");
      sfr_wr(`PPCR_ADDR_CFG_B4, `PPCR_PAGE_DRV_HI, 8'h2a);
      cmp8(d4, 8'h70, "p4 high grp");
      cmp8(d5 & d6, 8'hf0, "p5 p6 high");
      cmp8({5'h00, d7}, 8'h00, "p7 drive");
      chk_reg(`PPCR_ADDR_CFG_B4, `PPCR_PAGE_DRV_LO, 8'h5a, "dlo kept");
   endtask

   // Unmapped pages neither hit, nor store, nor read back data
   task automatic test_unmapped;
      sfr_wr(`PPCR_ADDR_CFG_B4, 4'h0, 8'hff);
      sfr_wr(`PPCR_ADDR_CFG_B4, 4'h4, 8'hff);
      cmp8(d0 | u5, 8'hfc, "no stray write");
      chk_reg(`PPCR_ADDR_CFG_B4, 4'h0, 8'h00, "unmapped read");
      cmp8({7'h00, hit}, 8'h00, "no hit");
      page = `PPCR_PAGE_DRV_HI;
      #1;
      cmp8({7'h00, hit}, 8'h01, "hit");
   endtask

   // ------------------------------------------------------------
   // Main sequence, with a second reset in mid-run
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      test_reset();
      test_pullup();
      test_analog();
      test_drive();
      test_unmapped();
      @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      test_reset();
      conclude();
   end
endmodule
`default_nettype wire
